// file: rtl/cep_pkg.sv
package cep_pkg;

   // ----------------------------------------------------------------
   // exception vectors
   // ----------------------------------------------------------------
   localparam logic [31:0] VEC_RESET      = 32'h0000_0000;
   localparam logic [31:0] VEC_UNDEF      = 32'h0000_0004;
   localparam logic [31:0] VEC_TRAP       = 32'h0000_0008;
   localparam logic [31:0] VEC_PREFETCH   = 32'h0000_000c;
   localparam logic [31:0] VEC_DATA_ABORT = 32'h0000_0010;
   localparam logic [31:0] VEC_NORMAL_INT = 32'h0000_0018;
   localparam logic [31:0] VEC_FAST_INT   = 32'h0000_001c;

   // ----------------------------------------------------------------
   // boot signature check
   // ----------------------------------------------------------------
   localparam logic [31:0] BOOT_SIG_ADDR  = 32'h0000_0014;
   localparam logic [31:0] BOOT_SIG_WORD  = 32'h2701_1970;

   // ----------------------------------------------------------------
   // interrupt latency bounds, in core cycles
   // ----------------------------------------------------------------
   localparam int MIN_INT_CYC  = 5;
   localparam int MAX_FAST_CYC = 50;

   // ----------------------------------------------------------------
   // processing modes and banked register layout
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_USER   = 3'h0,
      MODE_FAST   = 3'h1,
      MODE_NORMAL = 3'h2,
      MODE_SUPER  = 3'h3,
      MODE_ABORT  = 3'h4,
      MODE_UNDEF  = 3'h5
   } cep_mode_t;

   localparam logic [3:0] REG_SP        = 4'hd;
   localparam logic [3:0] REG_LR        = 4'he;
   localparam logic [3:0] REG_FAST_LO   = 4'h8;
   localparam logic [3:0] REG_FAST_HI   = 4'hc;
   localparam logic [3:0] BANK_FAST_BASE = 4'ha;
   localparam int         BANK_DEPTH    = 16;
   localparam int         BANK_AW       = 4;

   // ----------------------------------------------------------------
   // transfer sizes
   // ----------------------------------------------------------------
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

endpackage

// file: rtl/cep_bank_mem.sv
`timescale 1ns/1ns
`default_nettype none
module cep_bank_mem
   import cep_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               we_i,
   input  wire logic [BANK_AW-1:0] waddr_i,
   input  wire logic [31:0]        wdata_i,
   input  wire logic [BANK_AW-1:0] raddr_i,
   output logic      [31:0]        rdata_o
);
   // ----------------------------------------------------------------
   // storage, registered read; no reset so it maps onto ram cells
   // ----------------------------------------------------------------
   logic [31:0] mem [BANK_DEPTH];

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule
`default_nettype wire

// file: rtl/cep_top.sv
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - priority: reset, data abort, fast, normal, prefetch, trap/undefined
// - vectors: reset 0x00, data abort 0x10, fast 0x1C, normal 0x18
// - vectors: prefetch abort 0x0C, software trap 0x08, undefined 0x04
// - trap and undefined share one level and are never both taken
// - pending fast interrupt wins over pending normal interrupt
// - after reset check word 0x14; a word matching neither signature nor page checksum enters download mode
// - first handler instruction always runs in 32-bit state
// - 32-bit instructions in full state, 16-bit in compressed state
// - one shared 32-bit bus, 8, 16 or 32 bit transfers
// - 32x32 multiply and multiply-accumulate with 64-bit result
// - breakpoint or watchpoint halts into debug state
// - debug state opens registers and memory to the debugger
// - exceptions enter privileged modes; both aborts share abort mode, reset and trap share supervisor
// - interrupt entry at least five cycles, fast at most fifty
// - modes bank stack pointer and link; fast also banks r8-r12
module cep_top
   import cep_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        fast_interrupt_i,
   input  wire logic        normal_int_i,
   input  wire logic        data_abort_i,
   input  wire logic        prefetch_abort_i,
   input  wire logic        software_trap_i,
   input  wire logic        undef_instr_i,
   input  wire logic        boundary_i,
   input  wire logic [31:0] return_pc_i,
   input  wire logic        to_compressed_i,
   input  wire logic        break_hit_i,
   input  wire logic        dbg_resume_i,
   input  wire logic        dbg_mem_req_i,
   input  wire logic [3:0]  reg_idx_i,
   input  wire logic [31:0] fetch_word_i,
   input  wire logic [31:0] fetch_addr_i,
   input  wire logic        boot_valid_i,
   input  wire logic [31:0] boot_data_i,
   input  wire logic [31:0] page0_sum_i,
   input  wire logic [1:0]  xfer_size_i,
   input  wire logic [1:0]  xfer_addr_i,
   input  wire logic        mul_go_i,
   input  wire logic        mul_signed_i,
   input  wire logic        mul_acc_i,
   input  wire logic [31:0] mul_a_i,
   input  wire logic [31:0] mul_b_i,
   input  wire logic [63:0] mul_add_i,
   output logic             boot_rd_o,
   output logic [31:0]      boot_addr_o,
   output logic             download_o,
   output logic             pc_load_o,
   output logic [31:0]      pc_vector_o,
   output logic [2:0]       mode_o,
   output logic             compressed_o,
   output logic             halt_o,
   output logic             dbg_access_o,
   output logic             dbg_mem_grant_o,
   output logic [31:0]      reg_data_o,
   output logic             reg_banked_o,
   output logic [31:0]      instr_o,
   output logic [3:0]       byte_en_o,
   output logic [63:0]      mul_result_o
);
   typedef enum logic [2:0] {
      ST_BOOT_RD = 3'h0, ST_RUN = 3'h1, ST_SAVE = 3'h2, ST_LOAD = 3'h3, ST_DEBUG = 3'h4, ST_DOWNLOAD = 3'h5
   } cep_state_t;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // maps a register index in a mode to its banked slot
   function automatic logic [BANK_AW:0] bank_map(input logic [2:0] m, input logic [3:0] idx);
      logic [BANK_AW-1:0] base;
      base = 4'({m - 3'h1, 1'b0});
      if (m == MODE_USER) begin
         bank_map = '0;
      end else if (idx == REG_SP) begin
         bank_map = {1'b1, base};
      end else if (idx == REG_LR) begin
         bank_map = {1'b1, base + 4'h1};
      end else if (m == MODE_FAST && idx >= REG_FAST_LO && idx <= REG_FAST_HI) begin
         bank_map = {1'b1, BANK_FAST_BASE + (idx - REG_FAST_LO)};
      end else begin
         bank_map = '0;
      end
   endfunction

   // ----------------------------------------------------------------
   // reset release and request synchronisers
   // ----------------------------------------------------------------
   logic       rst_q1;
   logic       rst_n;
   logic [1:0] int_q1;
   logic [1:0] int_q2;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_q1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n  <= rst_q1;
      end
   end

   // interrupt lines come from pins and other clock trees
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         int_q1 <= 2'h0;
         int_q2 <= 2'h0;
      end else begin
         int_q1 <= {fast_interrupt_i, normal_int_i};
         int_q2 <= int_q1;
      end
   end

   // ----------------------------------------------------------------
   // pending requests and priority
   // ----------------------------------------------------------------
   logic       pend_dabt;
   logic       pend_pabt;
   logic       pend_sw;
   logic       sw_is_undef;
   cep_state_t state;
   cep_state_t next_state;
   logic [2:0] ent_mode;
   logic [31:0] ent_vec;

   wire at_boundary = (state == ST_RUN) && boundary_i;
   wire req_fast    = int_q2[1];
   wire req_norm    = int_q2[0];
   wire any_req     = pend_dabt | req_fast | req_norm | pend_pabt | pend_sw;
   wire take        = at_boundary && any_req && !break_hit_i;
   wire sel_dabt    = pend_dabt;
   wire sel_fast    = !pend_dabt && req_fast;
   wire sel_norm    = !pend_dabt && !req_fast && req_norm;
   wire sel_pabt    = !pend_dabt && !req_fast && !req_norm && pend_pabt;
   wire sel_sw      = !pend_dabt && !req_fast && !req_norm && !pend_pabt && pend_sw;

   // one class per boundary; unselected aborts and traps stay latched, interrupts stay pending only while their lines hold
   wire [2:0] sel_mode = sel_dabt ? MODE_ABORT  :
                         sel_fast ? MODE_FAST   :
                         sel_norm ? MODE_NORMAL :
                         sel_pabt ? MODE_ABORT  :
                         sw_is_undef ? MODE_UNDEF : MODE_SUPER;
   wire [31:0] sel_vec = sel_dabt ? VEC_DATA_ABORT :
                         sel_fast ? VEC_FAST_INT   :
                         sel_norm ? VEC_NORMAL_INT :
                         sel_pabt ? VEC_PREFETCH   :
                         sw_is_undef ? VEC_UNDEF : VEC_TRAP;

   // aborts and traps are pulses; a new one in the take cycle wins
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pend_dabt   <= 1'b0;
         pend_pabt   <= 1'b0;
         pend_sw     <= 1'b0;
         sw_is_undef <= 1'b0;
      end else begin
         pend_dabt <= data_abort_i | (pend_dabt & !(take & sel_dabt));
         pend_pabt <= prefetch_abort_i | (pend_pabt & !(take & sel_pabt));
         pend_sw   <= software_trap_i | undef_instr_i | (pend_sw & !(take & sel_sw));
         // one shared level: an instruction is either a trap or undefined
         if (software_trap_i | undef_instr_i) begin
            sw_is_undef <= undef_instr_i;
         end
      end
   end

   // ----------------------------------------------------------------
   // entry sequencer
   // ----------------------------------------------------------------
   wire boot_ok = (boot_data_i == BOOT_SIG_WORD) || (boot_data_i == page0_sum_i);
   always_comb begin
      next_state = state;
      case (state)
         ST_BOOT_RD: begin
            if (boot_valid_i) begin
               next_state = boot_ok ? ST_SAVE : ST_DOWNLOAD;
            end
         end
         ST_RUN: begin
            if (at_boundary && break_hit_i) begin
               next_state = ST_DEBUG;
            end else if (take) begin
               next_state = ST_SAVE;
            end
         end
         ST_SAVE:     next_state = ST_LOAD;
         ST_LOAD:     next_state = ST_RUN;
         ST_DEBUG: begin
            if (dbg_resume_i) begin
               next_state = ST_RUN;
            end
         end
         ST_DOWNLOAD: next_state = ST_DOWNLOAD;
         default:     next_state = ST_BOOT_RD;
      endcase
   end

   logic        from_boot;
   logic        compressed;
   logic [31:0] saved_pc;
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state      <= ST_BOOT_RD;
         ent_mode   <= MODE_SUPER;
         ent_vec    <= VEC_RESET;
         saved_pc   <= 32'h0000_0000;
         from_boot  <= 1'b1;
         mode_o     <= MODE_SUPER;
         compressed <= 1'b0;
      end else begin
         state <= next_state;
         if (take) begin
            ent_mode  <= sel_mode;
            ent_vec   <= sel_vec;
            saved_pc  <= return_pc_i;
            from_boot <= 1'b0;
         end
         // handler starts in full-width state whatever ran before
         if (state == ST_SAVE) begin
            mode_o     <= ent_mode;
            compressed <= 1'b0;
         end else if (state == ST_RUN && to_compressed_i) begin
            compressed <= 1'b1;
         end
      end
   end

   assign pc_load_o    = (state == ST_LOAD);
   assign pc_vector_o  = ent_vec;
   assign compressed_o = compressed;
   assign boot_rd_o    = (state == ST_BOOT_RD);
   assign boot_addr_o  = BOOT_SIG_ADDR;
   assign download_o   = (state == ST_DOWNLOAD);
   assign halt_o       = (state == ST_DEBUG);
   // debugger reach is gated to the halted state only
   assign dbg_access_o    = halt_o;
   assign dbg_mem_grant_o = halt_o && dbg_mem_req_i;

   // ----------------------------------------------------------------
   // banked registers
   // ----------------------------------------------------------------
   wire [BANK_AW:0] lr_slot = bank_map(ent_mode, REG_LR);
   wire [BANK_AW:0] rd_slot = bank_map(mode_o, reg_idx_i);
   // link is written in save, one cycle before the vector load
   wire bank_we = (state == ST_SAVE) && !from_boot;

   cep_bank_mem u_bank (
      .clk_i   (clk_i),
      .we_i    (bank_we),
      .waddr_i (lr_slot[BANK_AW-1:0]),
      .wdata_i (saved_pc),
      .raddr_i (rd_slot[BANK_AW-1:0]),
      .rdata_o (reg_data_o)
   );

   // ----------------------------------------------------------------
   // fetch decode, byte lanes and multiplier
   // ----------------------------------------------------------------
   wire [15:0] half_sel = fetch_addr_i[1] ? fetch_word_i[31:16] : fetch_word_i[15:0];
   wire [3:0]  lane_mask = (xfer_size_i == SIZE_WORD) ? 4'hf :
                           (xfer_size_i == SIZE_HALF) ? (xfer_addr_i[1] ? 4'hc : 4'h3) :
                           4'(4'h1 << xfer_addr_i);
   wire [63:0] prod_s = 64'($signed(mul_a_i) * $signed(mul_b_i));
   wire [63:0] prod_u = mul_a_i * mul_b_i;
   wire [63:0] prod   = mul_signed_i ? prod_s : prod_u;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         instr_o      <= 32'h0000_0000;
         byte_en_o    <= 4'h0;
         mul_result_o <= 64'h0000_0000_0000_0000;
         reg_banked_o <= 1'b0;
      end else begin
         // hit flag registered so it lines up with the bank read data
         reg_banked_o <= rd_slot[BANK_AW];
         instr_o   <= compressed ? {16'h0000, half_sel} : fetch_word_i;
         byte_en_o <= lane_mask;
         if (mul_go_i) begin
            mul_result_o <= mul_acc_i ? prod + mul_add_i : prod;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [7:0] fast_wait;
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         fast_wait <= 8'h00;
      end else if (!int_q2[1] || (pc_load_o && ent_vec == VEC_FAST_INT)) begin
         fast_wait <= 8'h00;
      end else if (state == ST_RUN || state == ST_SAVE || state == ST_LOAD) begin
         fast_wait <= fast_wait + 8'h01;
      end
   end
   dabt_first_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      take && pend_dabt |=> ent_vec == VEC_DATA_ABORT && ent_mode == MODE_ABORT)
      else $error("data abort lost priority");
   fast_over_norm_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      take && !pend_dabt && req_fast |=> ent_vec == VEC_FAST_INT)
      else $error("fast interrupt not taken first");
   norm_vector_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      take && sel_norm |-> ##2 pc_load_o && pc_vector_o == VEC_NORMAL_INT && mode_o == MODE_NORMAL)
      else $error("normal interrupt vector wrong");
   low_vectors_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      take && sel_pabt |-> ##2 pc_load_o && pc_vector_o == VEC_PREFETCH)
      else $error("prefetch abort vector wrong");
   trap_or_undef_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      take && sel_sw |=> (ent_vec == VEC_UNDEF) == (ent_mode == MODE_UNDEF))
      else $error("trap and undefined mixed");
   boot_check_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      state == ST_BOOT_RD && boot_valid_i && !boot_ok |=> download_o [*3])
      else $error("bad boot word ran user code");
   full_state_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      pc_load_o |-> !compressed_o)
      else $error("handler entered in compressed state");
   break_halt_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      at_boundary && break_hit_i |=> halt_o && !pc_load_o)
      else $error("breakpoint did not halt");
   min_latency_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      $rose(normal_int_i) && !int_q1[0] && !int_q2[0] |-> !(pc_load_o && pc_vector_o == VEC_NORMAL_INT) [*4])
      else $error("interrupt entry under five cycles");
   max_fast_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      fast_wait < 8'(MAX_FAST_CYC))
      else $error("fast interrupt entry over fifty cycles");
   link_first_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      bank_we |=> pc_load_o)
      else $error("link not saved before vector");
   pend_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      take && sel_dabt && pend_pabt |=> pend_pabt)
      else $error("lower request dropped");
endmodule
`default_nettype wire

// file: tb/cep_boot_model.sv
`timescale 1ns/1ns
`default_nettype none
module cep_boot_model
   import cep_pkg::*;
#(
   parameter logic [31:0] PAGE_SUM = 32'h1234_5678
)(
   input  wire logic        clk_i,
   input  wire logic        rd_i,
   input  wire logic [1:0]  sel_i,
   input  wire logic [3:0]  lag_i,
   output logic             valid_o,
   output logic [31:0]      data_o,
   output logic [31:0]      sum_o
);
   // ----------------------------------------------------------------
   // stored image word at the reserved vector slot
   // ----------------------------------------------------------------
   logic [3:0]  wait_cnt;
   wire  [31:0] image_word = (sel_i == 2'h0) ? BOOT_SIG_WORD :
                             (sel_i == 2'h1) ? PAGE_SUM : PAGE_SUM ^ 32'h0000_0001;
   assign sum_o = PAGE_SUM;
   initial begin
      valid_o = 1'b0;
      data_o = 32'h0;
      wait_cnt = 4'h0;
   end
   // a released bus toggles, so a stale word is never mistaken for a fresh one
   always @(posedge clk_i) begin
      if (rd_i && wait_cnt >= lag_i) begin
         valid_o <= 1'b1;
         data_o <= image_word;
      end else begin
         valid_o <= 1'b0;
         data_o <= ~data_o;
         wait_cnt <= rd_i ? wait_cnt + 4'h1 : 4'h0;
      end
   end
endmodule
`default_nettype wire

// file: tb/cep_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module cep_top_bench import cep_pkg::*;;
   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   logic clk_i = 1'b0, rst_b_i = 1'b0, fast_interrupt_i = 1'b0, normal_int_i = 1'b0, data_abort_i = 1'b0;
   logic prefetch_abort_i = 1'b0, software_trap_i = 1'b0, undef_instr_i = 1'b0, boundary_i = 1'b1;
   logic to_compressed_i = 1'b0, break_hit_i = 1'b0, dbg_resume_i = 1'b0, dbg_mem_req_i = 1'b0;
   logic mul_go_i = 1'b0, mul_signed_i = 1'b0, mul_acc_i = 1'b0;
   logic [31:0] return_pc_i = 32'h100, fetch_word_i = 32'h0, fetch_addr_i = 32'h0, mul_a_i = 32'h0, mul_b_i = 32'h0;
   logic [63:0] mul_add_i = 64'h0;
   logic [3:0]  reg_idx_i = 4'h0, lag = 4'h0;
   logic [1:0]  xfer_size_i = 2'h0, xfer_addr_i = 2'h0, sel = 2'h0;
   wire logic boot_valid_i, boot_rd_o, download_o, pc_load_o, compressed_o, halt_o, dbg_access_o;
   wire logic dbg_mem_grant_o, reg_banked_o;
   wire logic [31:0] boot_data_i, page0_sum_i, boot_addr_o, pc_vector_o, reg_data_o, instr_o;
   wire logic [2:0]  mode_o;
   wire logic [3:0]  byte_en_o;
   wire logic [63:0] mul_result_o;
   int error_cnt = 0, cmp_count = 0, lat = 0;
   localparam logic [31:0] MA [4] = '{32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'h3};
   localparam logic [31:0] MB [4] = '{32'hffff_ffff, 32'h2, 32'hffff_ffff, 32'hffff_fffe};
   localparam logic [63:0] MR [4] = '{64'hffff_fffe_0000_0001, 64'h1_ffff_ffff, 64'h1, 64'h4};
   localparam logic [7:0]  LN [5] = '{{SIZE_BYTE, 2'h0, 4'h1}, {SIZE_BYTE, 2'h3, 4'h8},
      {SIZE_HALF, 2'h2, 4'hc}, {SIZE_HALF, 2'h0, 4'h3}, {SIZE_WORD, 2'h0, 4'hf}};

   cep_top u_dut (.clk_i, .rst_b_i, .fast_interrupt_i, .normal_int_i, .data_abort_i, .prefetch_abort_i,
      .software_trap_i, .undef_instr_i, .boundary_i, .return_pc_i, .to_compressed_i, .break_hit_i, .dbg_resume_i,
      .dbg_mem_req_i, .reg_idx_i, .fetch_word_i, .fetch_addr_i, .boot_valid_i, .boot_data_i, .page0_sum_i,
      .xfer_size_i, .xfer_addr_i, .mul_go_i, .mul_signed_i, .mul_acc_i, .mul_a_i, .mul_b_i, .mul_add_i,
      .boot_rd_o, .boot_addr_o, .download_o, .pc_load_o, .pc_vector_o, .mode_o, .compressed_o, .halt_o,
      .dbg_access_o, .dbg_mem_grant_o, .reg_data_o, .reg_banked_o, .instr_o, .byte_en_o, .mul_result_o);
   cep_boot_model u_mem (.clk_i, .rd_i(boot_rd_o), .sel_i(sel), .lag_i(lag), .valid_o(boot_valid_i),
      .data_o(boot_data_i), .sum_o(page0_sum_i));

   always #50 clk_i = ~clk_i;

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input int n, input int lo, input int hi);
      cmp_count++;
      if (n < lo || n > hi) begin
         error_cnt++;
         $display("[ERR] %0t count %0d outside %0d..%0d", $time, n, lo, hi);
      end
   endtask
   // outputs are judged at falling edges, after the rising edge updates have landed
   task automatic wait_load(output int n);
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (pc_load_o !== 1'b1 && n < 60);
   endtask
   task automatic entry(input logic [31:0] vec, input logic [2:0] mode);
      wait_load(lat);
      chk(pc_vector_o, vec);
      chk(mode_o, mode);
      chk(compressed_o, 1'b0);
      @(posedge clk_i);
      boundary_i <= 1'b0;
      fast_interrupt_i <= fast_interrupt_i & (vec != VEC_FAST_INT);
      normal_int_i <= normal_int_i & (vec != VEC_NORMAL_INT);
      reg_idx_i <= REG_LR;
      @(posedge clk_i);
      reg_idx_i <= REG_FAST_LO;
      @(negedge clk_i);
      if (vec != VEC_RESET) chk(reg_data_o, return_pc_i);
      chk(reg_banked_o, 1'b1);
      @(negedge clk_i);
      chk(reg_banked_o, mode == MODE_FAST);
      repeat (3) @(posedge clk_i);
      return_pc_i <= return_pc_i + 32'h4;
      boundary_i <= 1'b1;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic boot(input logic [1:0] s, input logic [3:0] l);
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      sel <= s;
      lag <= l;
      @(negedge clk_i);
      chk({boot_rd_o, pc_load_o, halt_o, download_o}, 4'h8);
      repeat (5) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(negedge clk_i);
      chk(boot_addr_o, BOOT_SIG_ADDR);
      if (s == 2'h2) begin
         wait_load(lat);
         chk({download_o, lat[7:0]}, {1'b1, 8'h3c});
      end else begin
         entry(VEC_RESET, MODE_SUPER);
      end
   endtask
   task automatic prio();
      @(posedge clk_i);
      {data_abort_i, prefetch_abort_i, software_trap_i, fast_interrupt_i, normal_int_i} <= 5'h1f;
      @(posedge clk_i);
      {data_abort_i, prefetch_abort_i, software_trap_i} <= 3'h0;
      entry(VEC_DATA_ABORT, MODE_ABORT);
      entry(VEC_FAST_INT, MODE_FAST);
      entry(VEC_NORMAL_INT, MODE_NORMAL);
      entry(VEC_PREFETCH, MODE_ABORT);
      entry(VEC_TRAP, MODE_SUPER);
   endtask
   task automatic latency();
      @(posedge clk_i);
      fast_interrupt_i <= 1'b1;
      normal_int_i <= 1'b1;
      entry(VEC_FAST_INT, MODE_FAST);
      chk_rng(lat, MIN_INT_CYC, MAX_FAST_CYC);
      entry(VEC_NORMAL_INT, MODE_NORMAL);
   endtask
   task automatic pair();
      @(posedge clk_i);
      {software_trap_i, undef_instr_i} <= 2'h3;
      @(posedge clk_i);
      {software_trap_i, undef_instr_i} <= 2'h0;
      entry(VEC_UNDEF, MODE_UNDEF);
      wait_load(lat);
      chk(lat, 60);
   endtask
   task automatic debug();
      @(posedge clk_i);
      {break_hit_i, data_abort_i, dbg_mem_req_i} <= 3'h7;
      @(posedge clk_i);
      {break_hit_i, data_abort_i} <= 2'h0;
      repeat (6) @(negedge clk_i);
      chk({halt_o, dbg_access_o, dbg_mem_grant_o, pc_load_o}, 4'he);
      @(posedge clk_i);
      dbg_mem_req_i <= 1'b0;
      dbg_resume_i <= 1'b1;
      @(posedge clk_i);
      dbg_resume_i <= 1'b0;
      @(negedge clk_i);
      chk(halt_o, 1'b0);
      entry(VEC_DATA_ABORT, MODE_ABORT);
   endtask
   task automatic half_fetch();
      @(posedge clk_i);
      fetch_word_i <= 32'haaaa_5555;
      fetch_addr_i <= 32'h0000_0102;
      to_compressed_i <= 1'b1;
      @(posedge clk_i);
      to_compressed_i <= 1'b0;
      @(negedge clk_i);
      chk(instr_o, 32'haaaa_5555);
      chk(compressed_o, 1'b1);
      @(negedge clk_i);
      chk(instr_o, 32'h0000_aaaa);
      @(posedge clk_i);
      fetch_addr_i <= 32'h0000_0100;
      prefetch_abort_i <= 1'b1;
      @(posedge clk_i);
      prefetch_abort_i <= 1'b0;
      @(negedge clk_i);
      chk(instr_o, 32'h0000_5555);
      entry(VEC_PREFETCH, MODE_ABORT);
   endtask
   task automatic mul_lanes();
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         {mul_go_i, mul_signed_i, mul_acc_i} <= {1'b1, 2'(i)};
         {mul_a_i, mul_b_i} <= {MA[i], MB[i]};
         mul_add_i <= (i == 3) ? 64'ha : 64'h1;
         @(posedge clk_i);
         mul_go_i <= 1'b0;
         @(negedge clk_i);
         chk(mul_result_o, MR[i]);
      end
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_i);
         {xfer_size_i, xfer_addr_i} <= LN[i][7:4];
         @(posedge clk_i);
         @(negedge clk_i);
         chk(byte_en_o, LN[i][3:0]);
      end
   endtask

   initial begin
      boot(2'h2, 4'h0);
      boot(2'h1, 4'hc);
      boot(2'h0, 4'h0);
      prio();
      latency();
      pair();
      debug();
      half_fetch();
      mul_lanes();
      stop_test();
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      error_cnt++;
      $display("[ERR] %0t watchdog expired", $time);
      stop_test();
   end
endmodule
`default_nettype wire
